// [inc/scard_map.vh]
// constants shared by the smart card interface control logic
// assumes a 40 MHz system clock; included by bare name from logic/
`ifndef SCARD_MAP_VH
`define SCARD_MAP_VH

// system clock rate and the card insertion debounce time
`define CLK_SYS_KHZ      40000
`define DEBOUNCE_MS      8
`define DEBOUNCE_CYC     20'h4e200 // DEBOUNCE_MS of CLK_SYS_KHZ clocks
`define DEBOUNCE_W       20

// card supply level codes on card_supply_out
`define SUPPLY_OFF       2'h0
`define SUPPLY_3V0       2'h1
`define SUPPLY_5V0       2'h2
`define SUPPLY_1V8       2'h3

// divider lookup: two bits per select value, log2 of the ratio,
// entry for select 0 in the low bits (0=1/1, 1=1/2, 2=1/4, 3=1/8)
`define DIV_MAP_DEFAULT  8'he4

// release guard after a relayed low, in system clocks
`define LINE_GUARD_CYC   3'h4

// bit positions inside the synchronised pin vector
`define SY_DETECT        0
`define SY_CMD_N         1
`define SY_VSEL_A        2
`define SY_VSEL_B        3
`define SY_DIV_A         4
`define SY_DIV_B         5
`define SY_RST           6
`define SY_LOW           7
`define SY_OVL           8
`define SY_SRC_CLK       9
`define SY_HOST_LINES    10
`define SY_CARD_LINES    13
`define SY_WIDTH         16
// reset image: command high, all six line inputs idle high, rest low
`define SY_RESET_VAL     16'hfc02

`endif

// [logic/pin_sync.v]
// two-flop synchroniser for a group of asynchronous pin inputs
// assumes each bit is an independent level; no bus coherence is kept
`timescale 1ns/1ps
module pin_sync #(
  parameter             W         = 1,
  parameter [W-1:0]     RESET_VAL = {W{1'b0}}
) (
  input  wire           clk_sys,
  input  wire           arst_n,
  input  wire           clk_en,
  input  wire [W-1:0]   pin_in,
  output reg  [W-1:0]   pin_sync_out
);

  reg [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg     <= RESET_VAL;
      pin_sync_out <= RESET_VAL;
    end else if (clk_en) begin
      meta_reg     <= pin_in;
      pin_sync_out <= meta_reg;
    end
  end

endmodule // pin_sync

// [logic/clock_divider.v]
// card clock divider driven from the sampled source clock level
// assumes source_clock is below half the system clock rate
`timescale 1ns/1ps
module clock_divider (
  input  wire       clk_sys,
  input  wire       arst_n,
  input  wire       clk_en,
  input  wire       src_level,
  input  wire       enable,
  input  wire [1:0] ratio_log2,
  output reg        card_clk
);

  reg       prev_reg;
  reg [2:0] count_reg;
  wire      src_rise;
  reg       clk_next;

  assign src_rise = src_level & ~prev_reg;

  // bit k of the rise counter runs at 1/2^(k+1) of the source
  always @* begin
    case (ratio_log2)
      2'h0:    clk_next = src_level;
      2'h1:    clk_next = count_reg[0];
      2'h2:    clk_next = count_reg[1];
      2'h3:    clk_next = count_reg[2];
      default: clk_next = src_level;
    endcase
  end

  // disabled divider parks low on the next enabled clock, cutting any high phase short
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prev_reg  <= 1'b0;
      count_reg <= 3'h0;
      card_clk  <= 1'b0;
    end else if (clk_en) begin
      prev_reg <= src_level;
      if (!enable) begin
        count_reg <= 3'h0;
        card_clk  <= 1'b0;
      end else begin
        if (src_rise)
          count_reg <= count_reg + 3'h1;
        card_clk <= clk_next;
      end
    end
  end

endmodule // clock_divider

// [logic/smart_card_interface_control.v]
// pin-level control of a smart card interface: activation, supply
// select, clock division, reset pass-through, line relays, interrupt
// assumes all inputs are asynchronous pins; lines are open-drain style
//
// Overview of operation
// - falling power command with card present starts activation
// - power command is active low; high keeps the card interface off
// - select b low gives 3 V; else a low 5 V, a high 1.8 V
// - host supply below lockout disables every card-side pin
// - interrupt output goes low on a detected card presence
// - interrupt output also goes low on card supply overload
// - host reset request is passed to the card reset output
// - the two divider selects together choose the clock ratio
// - serial data line is relayed both ways, idles released
// - c4 auxiliary line relayed both ways like the data line
// - c8 auxiliary line relayed both ways like the data line
// - card insertion is debounced for about 8 ms
// - ratios 1/1, 1/2, 1/4 and 1/8 are supported
// - card clock comes from the source clock through the divider
`timescale 1ns/1ps
`include "scard_map.vh"
module smart_card_interface_control #(
  parameter [`DEBOUNCE_W-1:0] DEBOUNCE_CYCLES    = `DEBOUNCE_CYC,
  parameter                   DETECT_ACTIVE_HIGH = 0,
  parameter [7:0]             DIV_MAP            = `DIV_MAP_DEFAULT
) (
  input  wire       clk_sys,
  input  wire       arst_n,
  input  wire       clk_en,
  input  wire       card_detect,
  input  wire       card_power_command_n,
  input  wire       supply_select_a,
  input  wire       supply_select_b,
  input  wire       divider_select_a,
  input  wire       divider_select_b,
  input  wire       host_reset_request,
  input  wire       supply_low,
  input  wire       supply_overload,
  input  wire       source_clock,
  input  wire       host_io_line_in,
  output wire       host_io_line_out,
  output wire       host_io_line_oe,
  input  wire       host_aux_c4_line_in,
  output wire       host_aux_c4_line_out,
  output wire       host_aux_c4_line_oe,
  input  wire       host_aux_c8_line_in,
  output wire       host_aux_c8_line_out,
  output wire       host_aux_c8_line_oe,
  input  wire       card_io_line_in,
  output wire       card_io_line_out,
  output wire       card_io_line_oe,
  input  wire       card_c4_line_in,
  output wire       card_c4_line_out,
  output wire       card_c4_line_oe,
  input  wire       card_c8_line_in,
  output wire       card_c8_line_out,
  output wire       card_c8_line_oe,
  output reg  [1:0] card_supply_out,
  output reg        card_reset_out,
  output wire       card_clock_out,
  output reg        int_n,
  output wire       card_present,
  output wire       card_active
);

  // activation states
  localparam ST_OFF = 1'b0;
  localparam ST_ON  = 1'b1;

  // line relay states
  localparam RL_IDLE  = 2'h0;
  localparam RL_HOST  = 2'h1;
  localparam RL_CARD  = 2'h2;
  localparam RL_GUARD = 2'h3;

  wire [`SY_WIDTH-1:0]   pins_raw;
  wire [`SY_WIDTH-1:0]   pins_s;
  wire                   det_s;
  wire                   cmd_n_s;
  wire                   low_s;
  wire                   ovl_s;
  wire                   rst_s;
  wire [2:0]             host_lines_s;
  wire [2:0]             card_lines_s;
  wire                   det_level;
  wire [1:0]             div_sel;
  wire [1:0]             div_ratio;
  wire                   cmd_fall;
  wire                   cmd_change;
  wire                   pins_enabled;
  wire [2:0]             host_oe;
  wire [2:0]             card_oe;

  reg                    state_reg;
  reg                    state_next;
  reg                    cmd_prev_reg;
  reg                    present_reg;
  reg [`DEBOUNCE_W-1:0]  deb_cnt_reg;
  reg                    insert_evt_reg;
  reg                    remove_evt_reg;
  reg                    int_pend_reg;
  reg                    int_pend_next;
  reg [1:0]              level_sel;

  // gather every asynchronous pin into one synchroniser bank
  assign pins_raw = {card_c8_line_in, card_c4_line_in, card_io_line_in,
                     host_aux_c8_line_in, host_aux_c4_line_in,
                     host_io_line_in, source_clock, supply_overload,
                     supply_low, host_reset_request, divider_select_b,
                     divider_select_a, supply_select_b, supply_select_a,
                     card_power_command_n, card_detect};

  pin_sync #( // detect bit resets to the no-card level, so no false count
    .W         (`SY_WIDTH),
    .RESET_VAL (`SY_RESET_VAL | {15'h0000, DETECT_ACTIVE_HIGH == 0})
  ) u_pin_sync (
    .clk_sys      (clk_sys),
    .arst_n       (arst_n),
    .clk_en       (clk_en),
    .pin_in       (pins_raw),
    .pin_sync_out (pins_s)
  );

  // named views of the synchronised pins
  assign det_s        = pins_s[`SY_DETECT];
  assign cmd_n_s      = pins_s[`SY_CMD_N];
  assign low_s        = pins_s[`SY_LOW];
  assign ovl_s        = pins_s[`SY_OVL];
  assign rst_s        = pins_s[`SY_RST];
  assign host_lines_s = pins_s[`SY_HOST_LINES +: 3];
  assign card_lines_s = pins_s[`SY_CARD_LINES +: 3];

  // connector polarity is a build option, so map to "card seen"
  assign det_level = (DETECT_ACTIVE_HIGH != 0) ? det_s : ~det_s;

  // insertion waits out contact bounce; removal acts at once so a
  // pulled card is powered down without delay
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      deb_cnt_reg    <= {`DEBOUNCE_W{1'b0}};
      present_reg    <= 1'b0;
      insert_evt_reg <= 1'b0;
      remove_evt_reg <= 1'b0;
    end else if (clk_en) begin
      insert_evt_reg <= 1'b0;
      remove_evt_reg <= 1'b0;
      if (!det_level) begin
        deb_cnt_reg    <= {`DEBOUNCE_W{1'b0}};
        present_reg    <= 1'b0;
        remove_evt_reg <= present_reg;
      end else if (!present_reg) begin
        if (deb_cnt_reg >= DEBOUNCE_CYCLES - 1'b1) begin
          present_reg    <= 1'b1;
          insert_evt_reg <= 1'b1;
        end else begin
          deb_cnt_reg <= deb_cnt_reg + 1'b1;
        end
      end
    end
  end

  // edges of the power command; the previous copy resets high
  assign cmd_fall   = cmd_prev_reg & ~cmd_n_s;
  assign cmd_change = cmd_prev_reg ^ cmd_n_s;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      cmd_prev_reg <= 1'b1;
    else if (clk_en)
      cmd_prev_reg <= cmd_n_s;
  end

  // activation only on a fresh falling edge, so a command held low
  // through an insertion does not start the card by itself
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (cmd_fall && present_reg && !low_s && !ovl_s)
          state_next = ST_ON;
      end
      ST_ON: begin
        if (cmd_n_s)
          state_next = ST_OFF;
        else if (!present_reg || ovl_s)
          state_next = ST_OFF;
        else if (low_s)
          state_next = ST_OFF;
      end
      default: state_next = ST_OFF;
    endcase
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      state_reg <= ST_OFF;
    else if (clk_en)
      state_reg <= state_next;
  end

  // lockout gates the pins directly as well, with no state delay
  assign pins_enabled = (state_reg == ST_ON) & ~low_s;
  assign card_active  = pins_enabled;
  assign card_present = present_reg;

  // supply level decode: select b low means 3 V whatever a is
  always @* begin
    if (!pins_s[`SY_VSEL_B])
      level_sel = `SUPPLY_3V0;
    else if (pins_s[`SY_VSEL_A])
      level_sel = `SUPPLY_1V8;
    else
      level_sel = `SUPPLY_5V0;
  end

  // supply and reset follow the host only while the card is live;
  // reset rides at whatever level the supply code names
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      card_supply_out <= `SUPPLY_OFF;
      card_reset_out  <= 1'b0;
    end else if (clk_en) begin
      card_supply_out <= pins_enabled ? level_sel : `SUPPLY_OFF;
      card_reset_out  <= pins_enabled & rst_s;
    end
  end

  // ratio lookup indexed by the combined selects
  assign div_sel   = {pins_s[`SY_DIV_B], pins_s[`SY_DIV_A]};
  assign div_ratio = DIV_MAP[{div_sel, 1'b0} +: 2];

  clock_divider u_clock_divider (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .clk_en     (clk_en),
    .src_level  (pins_s[`SY_SRC_CLK]),
    .enable     (pins_enabled),
    .ratio_log2 (div_ratio),
    .card_clk   (card_clock_out)
  );

  // interrupt: set wins over the acknowledge in the same cycle, and
  // a standing overload keeps the request from being cleared
  always @* begin
    int_pend_next = int_pend_reg;
    if (cmd_change && !ovl_s)
      int_pend_next = 1'b0;
    if (insert_evt_reg || remove_evt_reg)
      int_pend_next = 1'b1;
    if (ovl_s)
      int_pend_next = 1'b1;
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      int_pend_reg <= 1'b0;
      int_n        <= 1'b1;
    end else if (clk_en) begin
      int_pend_reg <= int_pend_next;
      int_n        <= ~int_pend_next;
    end
  end

  // one relay per line: whichever side pulls low first owns the line
  // until it lets go; a guard then masks the echo of our own drive,
  // which returns through the synchroniser two cycles late
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_relay
      reg [1:0] rl_state_reg;
      reg [1:0] rl_state_next;
      reg [2:0] guard_reg;

      always @* begin
        rl_state_next = rl_state_reg;
        case (rl_state_reg)
          RL_IDLE: begin
            if (pins_enabled && !host_lines_s[gi])
              rl_state_next = RL_HOST;
            else if (pins_enabled && !card_lines_s[gi])
              rl_state_next = RL_CARD;
          end
          RL_HOST: begin
            if (!pins_enabled || host_lines_s[gi])
              rl_state_next = RL_GUARD;
          end
          RL_CARD: begin
            if (!pins_enabled || card_lines_s[gi])
              rl_state_next = RL_GUARD;
          end
          RL_GUARD: begin
            if (guard_reg == 3'h0)
              rl_state_next = RL_IDLE;
          end
          default: rl_state_next = RL_IDLE;
        endcase
      end

      always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          rl_state_reg <= RL_IDLE;
          guard_reg    <= 3'h0;
        end else if (clk_en) begin
          rl_state_reg <= rl_state_next;
          if (rl_state_next == RL_GUARD && rl_state_reg != RL_GUARD)
            guard_reg <= `LINE_GUARD_CYC;
          else if (guard_reg != 3'h0)
            guard_reg <= guard_reg - 3'h1;
        end
      end

      // drive low only; released level comes from the pull-ups
      assign card_oe[gi] = (rl_state_reg == RL_HOST);
      assign host_oe[gi] = (rl_state_reg == RL_CARD);
    end
  endgenerate

  // data line relay
  assign card_io_line_oe  = card_oe[0] & pins_enabled;
  assign host_io_line_oe  = host_oe[0] & pins_enabled;
  assign card_io_line_out = 1'b0;
  assign host_io_line_out = 1'b0;

  // c4 auxiliary relay
  assign card_c4_line_oe      = card_oe[1] & pins_enabled;
  assign host_aux_c4_line_oe  = host_oe[1] & pins_enabled;
  assign card_c4_line_out     = 1'b0;
  assign host_aux_c4_line_out = 1'b0;

  // c8 auxiliary relay
  assign card_c8_line_oe      = card_oe[2] & pins_enabled;
  assign host_aux_c8_line_oe  = host_oe[2] & pins_enabled;
  assign card_c8_line_out     = 1'b0;
  assign host_aux_c8_line_out = 1'b0;

endmodule // smart_card_interface_control

// [dv/smart_card_interface_control_chk.sv]
// port-level checker for the smart card interface control block
// assumes one clk_sys domain and pins that move away from the edge
`timescale 1ns/1ps
`include "scard_map.vh"
module smart_card_interface_control_chk (
  input wire       clk_sys,
  input wire       arst_n,
  input wire       card_power_command_n,
  input wire       supply_select_a,
  input wire       supply_select_b,
  input wire       host_reset_request,
  input wire       supply_low,
  input wire       supply_overload,
  input wire       host_io_line_in,
  input wire       host_io_line_oe,
  input wire       card_io_line_oe,
  input wire       card_c4_line_in,
  input wire       card_c4_line_oe,
  input wire       host_aux_c4_line_oe,
  input wire [1:0] card_supply_out,
  input wire       card_reset_out,
  input wire       card_clock_out,
  input wire       int_n,
  input wire       card_present,
  input wire       card_active
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire [2:0] cfg_pins = {supply_select_a, supply_select_b, host_reset_request};
  reg  [2:0] cfg_last_reg;
  reg  [2:0] cfg_age_reg;
  reg        cmd_last_reg;
  reg  [2:0] cmd_age_reg;
  // ages saturate at 7 so a long quiet spell never wraps
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_last_reg <= 3'h0;
      cfg_age_reg  <= 3'h0;
      cmd_last_reg <= 1'b1;
      cmd_age_reg  <= 3'h7;
    end else begin
      cfg_last_reg <= cfg_pins;
      cmd_last_reg <= card_power_command_n;
      cfg_age_reg  <= (cfg_pins != cfg_last_reg) ? 3'h0 :
                      (cfg_age_reg == 3'h7) ? 3'h7 : cfg_age_reg + 3'h1;
      cmd_age_reg  <= (card_power_command_n != cmd_last_reg) ? 3'h0 :
                      (cmd_age_reg == 3'h7) ? 3'h7 : cmd_age_reg + 3'h1;
    end
  end
  a_activation_start:
    assert property ($fell(card_power_command_n) && card_present &&
      !supply_low && !supply_overload |-> ##3 card_active)
    else $error("command fall with card present did not activate");
  a_command_high_off:
    assert property (card_power_command_n[*4] |-> !card_active)
    else $error("card active while command high");
  a_supply_level:
    assert property (card_active[*2] ##0 (cfg_age_reg >= 3'h4 &&
      cfg_pins == cfg_last_reg) |->
      card_supply_out == (!supply_select_b ? `SUPPLY_3V0 :
      !supply_select_a ? `SUPPLY_5V0 : `SUPPLY_1V8))
    else $error("card supply code differs from selects");
  a_reset_follows:
    assert property (card_active[*2] ##0 (cfg_age_reg >= 3'h4 &&
      cfg_pins == cfg_last_reg) |->
      card_reset_out == host_reset_request)
    else $error("card reset does not follow host reset");
  a_lockout_pins:
    assert property (supply_low[*3] |-> !card_active && !card_io_line_oe
      && !card_c4_line_oe)
    else $error("card pins enabled under lockout");
  a_idle_outputs_off:
    assert property ((!card_active)[*3] |->
      card_supply_out == `SUPPLY_OFF && !card_clock_out)
    else $error("supply or clock on while inactive");
  a_int_on_present:
    assert property ($rose(card_present) |-> ##[0:1] !int_n)
    else $error("no interrupt on card presence");
  a_int_on_overload:
    assert property ($rose(supply_overload) |-> ##3 !int_n)
    else $error("no interrupt on overload");
  a_int_held_low:
    assert property (supply_overload[*4] |-> !int_n)
    else $error("interrupt released during overload");
  a_int_release_ack:
    assert property ($rose(int_n) |-> !supply_overload &&
      cmd_age_reg <= 3'h5)
    else $error("interrupt released without command change");
  a_relay_to_card:
    assert property ((card_active && !host_io_line_in &&
      !host_io_line_oe)[*8] |-> card_io_line_oe)
    else $error("host low not relayed to card");
  a_relay_c4_host:
    assert property ((card_active && !card_c4_line_in &&
      !card_c4_line_oe)[*8] |-> host_aux_c4_line_oe)
    else $error("card c4 low not relayed to host");
  c_activation: cover property ($rose(card_active));
  c_overload_int: cover property (supply_overload && !int_n);
  c_relay_io: cover property (card_active && card_io_line_oe);
  c_lockout: cover property (supply_low && !card_active);
endmodule // smart_card_interface_control_chk

bind smart_card_interface_control smart_card_interface_control_chk u_chk (
  .clk_sys(clk_sys), .arst_n(arst_n),
  .card_power_command_n(card_power_command_n),
  .supply_select_a(supply_select_a), .supply_select_b(supply_select_b),
  .host_reset_request(host_reset_request), .supply_low(supply_low),
  .supply_overload(supply_overload), .host_io_line_in(host_io_line_in),
  .host_io_line_oe(host_io_line_oe), .card_io_line_oe(card_io_line_oe),
  .card_c4_line_in(card_c4_line_in), .card_c4_line_oe(card_c4_line_oe),
  .host_aux_c4_line_oe(host_aux_c4_line_oe),
  .card_supply_out(card_supply_out), .card_reset_out(card_reset_out),
  .card_clock_out(card_clock_out), .int_n(int_n),
  .card_present(card_present), .card_active(card_active));

// [dv/card_model.sv]
// behavioural smart card on the card side of the interface
// assumes the bench feeds line_level back to the card-side inputs
`timescale 1ns/1ps
module card_model (
  input  wire       inserted,
  input  wire [2:0] pull,
  input  wire [2:0] dut_oe,
  input  wire       card_clock_out,
  output wire       card_detect,
  output wire [2:0] line_level,
  output integer    clk_rises
);
  // normally open contact closes to ground when a card sits in
  assign card_detect = !inserted;
  // pulled-up contacts: a released line reads high, never the old value
  assign line_level = ~(pull | dut_oe);
  // count clock rises so the bench can judge the division ratio
  initial clk_rises = 0;
  always @(posedge card_clock_out) clk_rises = clk_rises + 1;
endmodule // card_model

// [dv/test_smart_card_interface_control.sv]
// self-checking bench for the smart card interface control block
// assumes card_model on the card side; the bench plays the host
`timescale 1ns/1ps
module test_smart_card_interface_control;
  localparam [7:0]  DIV_MAP_TB = 8'he4;
  localparam [19:0] DEB_CYC    = 20'h10;
  reg        clk_sys, arst_n, card_power_command_n, inserted;
  reg        supply_select_a, supply_select_b, host_reset_request;
  reg        divider_select_a, divider_select_b, supply_low;
  reg        supply_overload, source_clock, clk_en;
  reg  [2:0] host_pull, card_pull;
  wire [2:0] host_oe, host_out, card_oe, card_out, card_lvl, host_lvl;
  wire [1:0] card_supply_out;
  wire       card_reset_out, card_clock_out, int_n, card_present;
  wire       card_active, card_detect;
  integer    clk_rises, error_cnt, check_count, k, n, e, r0;
  // host-side lines carry pull-ups as well
  assign host_lvl = ~(host_pull | host_oe);
  smart_card_interface_control #(.DEBOUNCE_CYCLES(DEB_CYC),
    .DETECT_ACTIVE_HIGH(0), .DIV_MAP(DIV_MAP_TB)) u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
    .card_detect(card_detect), .card_power_command_n(card_power_command_n),
    .supply_select_a(supply_select_a), .supply_select_b(supply_select_b),
    .divider_select_a(divider_select_a),
    .divider_select_b(divider_select_b),
    .host_reset_request(host_reset_request), .supply_low(supply_low),
    .supply_overload(supply_overload), .source_clock(source_clock),
    .host_io_line_in(host_lvl[0]), .host_io_line_out(host_out[0]),
    .host_io_line_oe(host_oe[0]), .host_aux_c4_line_in(host_lvl[1]),
    .host_aux_c4_line_out(host_out[1]), .host_aux_c4_line_oe(host_oe[1]),
    .host_aux_c8_line_in(host_lvl[2]), .host_aux_c8_line_out(host_out[2]),
    .host_aux_c8_line_oe(host_oe[2]), .card_io_line_in(card_lvl[0]),
    .card_io_line_out(card_out[0]), .card_io_line_oe(card_oe[0]),
    .card_c4_line_in(card_lvl[1]), .card_c4_line_out(card_out[1]),
    .card_c4_line_oe(card_oe[1]), .card_c8_line_in(card_lvl[2]),
    .card_c8_line_out(card_out[2]), .card_c8_line_oe(card_oe[2]),
    .card_supply_out(card_supply_out), .card_reset_out(card_reset_out),
    .card_clock_out(card_clock_out), .int_n(int_n),
    .card_present(card_present), .card_active(card_active));
  card_model u_card (
    .inserted(inserted), .pull(card_pull), .dut_oe(card_oe),
    .card_clock_out(card_clock_out), .card_detect(card_detect),
    .line_level(card_lvl), .clk_rises(clk_rises));
  // 40 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // source clock at one eighth of the system rate, well under the limit
  initial begin
    source_clock = 1'b0;
    forever begin
      repeat (4) @(posedge clk_sys);
      #2 source_clock = ~source_clock;
    end
  end
  task tick(input integer c);
    begin
      repeat (c) @(posedge clk_sys);
      #2;
    end
  endtask
  task check(input [31:0] exp, input [31:0] got, input string what);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // model of the supply code: b low gives 3 V, else a picks 5 V or 1.8 V
  function integer exp_supply(input integer a, input integer b);
    exp_supply = (b == 0) ? 1 : (a == 0) ? 2 : 3;
  endfunction
  // command must be seen high before the fall that starts a session
  task activate;
    begin
      card_power_command_n = 1'b1;
      tick(6);
      card_power_command_n = 1'b0;
      tick(6);
    end
  endtask
  // main sequence
  initial begin
    {arst_n, inserted, supply_select_a, supply_select_b} = 4'h0;
    {divider_select_a, divider_select_b, host_reset_request} = 3'h0;
    {supply_low, supply_overload, host_pull, card_pull} = 8'h00;
    card_power_command_n = 1'b1;
    clk_en = 1'b1;
    error_cnt = 0;
    check_count = 0;
    r0 = $urandom(33);
    tick(16);
    arst_n = 1'b1;
    check(0, {card_supply_out, card_oe, host_oe, card_out, host_out},
      "reset outs");
    $display("test reset done");
    inserted = 1'b1;
    n = 0;
    while (card_present !== 1'b1 && n < 200) begin
      tick(1);
      n = n + 1;
    end
    if (n >= 200) begin
      check(1, 0, "present timeout");
      stop_test;
    end
    check(1, n >= DEB_CYC, "debounce");
    tick(2);
    check(0, int_n, "insert int");
    $display("test insertion done");
    activate;
    check(1, card_active, "active");
    check(1, int_n, "int ack");
    for (k = 0; k < 4; k = k + 1) begin
      {supply_select_b, supply_select_a} = k[1:0];
      host_reset_request = $urandom % 2;
      tick(6);
      check(exp_supply(k % 2, k / 2), card_supply_out, "supply");
      check(host_reset_request, card_reset_out, "reset");
    end
    $display("test supply done");
    for (k = 0; k < 4; k = k + 1) begin
      {divider_select_b, divider_select_a} = k[1:0];
      tick(16);
      r0 = clk_rises;
      tick(256);
      n = clk_rises - r0;
      e = 32 >> DIV_MAP_TB[2*k +: 2];
      if (n == e - 1 || n == e + 1) n = e;
      check(e, n, "clock rises");
    end
    // a low clock enable must freeze the divider along with all else
    clk_en = 1'b0;
    r0 = clk_rises;
    tick(64);
    check(r0, clk_rises, "frozen clock");
    clk_en = 1'b1;
    $display("test divider done");
    for (k = 0; k < 3; k = k + 1) begin
      host_pull[k] = 1'b1;
      tick(8 + $urandom % 8);
      check(0, card_lvl[k], "to card");
      host_pull[k] = 1'b0;
      tick(12);
      check(1, card_lvl[k], "card idle");
      card_pull[k] = 1'b1;
      tick(8 + $urandom % 8);
      check(0, host_lvl[k], "to host");
      card_pull[k] = 1'b0;
      tick(12);
      check(1, host_lvl[k], "host idle");
    end
    $display("test relay done");
    supply_overload = 1'b1;
    tick(5);
    check(0, int_n, "overload int");
    supply_overload = 1'b0;
    tick(6);
    check(0, int_n, "int held");
    card_power_command_n = 1'b1;
    tick(8);
    check(1, int_n, "int cleared");
    check(0, card_active, "cmd high");
    check(0, card_supply_out, "supply off");
    $display("test overload done");
    activate;
    supply_low = 1'b1;
    host_pull[0] = 1'b1;
    tick(8);
    check(0, {card_active, card_oe}, "lockout");
    host_pull[0] = 1'b0;
    supply_low = 1'b0;
    inserted = 1'b0;
    tick(8);
    activate;
    check(0, card_active, "no card");
    $display("test lockout done");
    stop_test;
  end
endmodule // test_smart_card_interface_control
